// ==== hw/aepc_device.sv ====
// Device end: register port, control line sampling and conversion pacing.
`timescale 1ns/10ps
module aepc_device
  import aepc_pkg::*;
#(
  parameter int unsigned pending_max = 15
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  aepc_link_if.device link,
  input wire logic [11:0] sample_in,
  output logic busy,
  output logic convert_strobe,
  output logic [3:0] convert_channel
);
  initial
  begin
    if (pending_max < 1 || pending_max > 255)
      $error("pending_max out of range");
  end
  aepc_state_t state;
  aepc_state_t next_state;
  logic [1:0] bypass_sync;
  logic [1:0] hold_sync;
  logic hold_prev;
  logic pulse_seen;
  logic [15:0] pace_interval;
  logic [7:0] pending;
  logic [3:0] last_channel;
  logic [15:0] stage1;
  logic [15:0] stage2;
  logic [19:0] count;
  logic [15:0] rdata_q;
  logic ack_q;
  wire bypass = bypass_sync[1];
  wire hold = hold_sync[1];
  wire hold_fall = hold_prev & ~hold;
  wire pace_hit = link.req & link.wr & (link.addr == pace_offset);
  wire data_hit = link.req & ~link.wr & (link.addr >= data_offset) & (link.addr <= data_top) & ~link.addr[0];
  wire queue_ok = data_hit & (pending < 8'(pending_max));
  wire [19:0] pace_steps = 20'(16'(pace_base - pace_interval));
  wire [19:0] pace_cycles = 20'(free_run_cycles) + 20'(pace_steps * 20'(pace_step_cycles));
  wire [19:0] gap_cycles = bypass ? 20'(free_run_cycles) : pace_cycles;
  wire count_done = (count == 20'd0);
  wire start_ok = (pending != 8'd0) & ~hold & (~pulse_seen | 1'b1);
  wire conv_done = (state == st_convert) & count_done;
  assign busy = (pending != 8'd0) | (state != st_idle);
  assign link.rdata = rdata_q;
  assign link.ack = ack_q;
  always_comb
  begin
    next_state = state;
    case (state)
      st_idle: if (start_ok) next_state = st_delay;
      st_wait: if (start_ok) next_state = st_pace;
      st_delay: if (count_done) next_state = st_convert;
      st_pace: if (count_done) next_state = st_convert;
      st_convert: if (count_done) next_state = (pending > 8'd1) ? st_wait : st_idle;
      default: next_state = st_idle;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bypass_sync <= 2'b00;
      hold_sync <= 2'b00;
      hold_prev <= 1'b0;
    end
    else if (clk_en)
    begin
      bypass_sync <= {bypass_sync[0], link.pace_bypass_line};
      hold_sync <= {hold_sync[0], link.external_hold_line};
      hold_prev <= hold;
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= st_idle;
      count <= 20'd0;
      pulse_seen <= 1'b0;
    end
    else if (clk_en)
    begin
      state <= next_state;
      if (state != next_state)
        count <= (next_state == st_delay) ? 20'(start_delay_cycles) :
          (next_state == st_convert) ? 20'(convert_cycles) :
          (next_state == st_pace) ? gap_cycles - 20'(convert_cycles) : 20'd0;
      else if (!count_done)
        count <= count - 20'd1;
      if (hold_fall)
        pulse_seen <= 1'b1;
      else if (conv_done)
        pulse_seen <= 1'b0;
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pace_interval <= pace_reset;
      pending <= 8'd0;
      last_channel <= 4'h0;
      stage1 <= 16'h0000;
      stage2 <= 16'h0000;
      rdata_q <= 16'h0000;
      ack_q <= 1'b0;
      convert_strobe <= 1'b0;
      convert_channel <= 4'h0;
    end
    else if (clk_en)
    begin
      ack_q <= link.req & ~ack_q;
      convert_strobe <= conv_done;
      if (pace_hit & ~ack_q)
        pace_interval <= link.wdata;
      if (data_hit & ~ack_q)
        rdata_q <= busy ? {1'b1, stage2[14:0]} : {1'b0, stage2[14:0]};
      else if (link.req & ~ack_q)
        rdata_q <= 16'h0000;
      if (queue_ok & ~ack_q)
        last_channel <= link.addr[4:1];
      if (conv_done)
      begin
        stage1 <= {4'h0, sample_in};
        stage2 <= stage1;
        convert_channel <= last_channel;
      end
      pending <= pending + 8'(queue_ok & ~ack_q) - 8'(conv_done);
    end
  end
endmodule

// ==== hw/aepc_host.sv ====
// Controller end: takes APB orders, drives the register port and the two pacing lines.
`timescale 1ns/10ps
module aepc_host
  import aepc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  aepc_link_if.host link
);
  aepc_host_state_t state;
  logic [7:0] addr_q;
  logic [15:0] pace_q;
  logic [15:0] data_q;
  logic bypass_q;
  logic hold_q;
  logic auto_lag;
  logic [7:0] pulse_len;
  logic [7:0] lag_len;
  logic [7:0] count;
  logic req_q;
  logic wr_q;
  logic busy_bit_seen;
  wire access = psel & penable;
  wire hit_ctl = paddr == ctl_offset;
  wire hit_stat = paddr == stat_offset;
  wire hit_pace = paddr == pace_reg_offset;
  wire hit_data = paddr == data_reg_offset;
  wire mapped = hit_ctl | hit_stat | hit_pace | hit_data;
  wire idle = state == hs_idle;
  wire [2:0] cmd = pwdata[26:24];
  wire do_cmd = access & pwrite & hit_ctl & idle;
  wire [7:0] len_new = (pwdata[7:0] < 8'(pulse_min_cycles)) ? 8'(pulse_min_cycles) : pwdata[7:0];
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
  assign link.req = req_q;
  assign link.wr = wr_q;
  assign link.addr = addr_q;
  assign link.wdata = pace_q;
  assign link.pace_bypass_line = bypass_q;
  assign link.external_hold_line = hold_q;
  always_comb
  begin
    prdata = 32'h00000000;
    if (hit_ctl)
      prdata = {12'h0, auto_lag, hold_q, bypass_q, 1'b0, addr_q, pulse_len};
    else if (hit_stat)
      prdata = {30'h0, busy_bit_seen, ~idle};
    else if (hit_pace)
      prdata = {16'h0, pace_q};
    else if (hit_data)
      prdata = {16'h0, data_q};
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= hs_idle;
      addr_q <= data_offset;
      pace_q <= pace_reset;
      data_q <= 16'h0000;
      bypass_q <= 1'b1;
      hold_q <= 1'b1;
      auto_lag <= 1'b0;
      pulse_len <= pulse_len_reset;
      lag_len <= bypass_lag_reset;
      count <= 8'h00;
      req_q <= 1'b0;
      wr_q <= 1'b0;
      busy_bit_seen <= 1'b0;
    end
    else if (clk_en)
    begin
      if (access & pwrite & hit_pace & idle)
        pace_q <= pwdata[15:0];
      if (do_cmd)
      begin
        pulse_len <= len_new;
        lag_len <= len_new;
        bypass_q <= pwdata[17];
        auto_lag <= pwdata[19];
        if (cmd == cmd_read)
        begin
          addr_q <= data_offset + {pwdata[14:8], 1'b0};
          wr_q <= 1'b0;
          req_q <= 1'b1;
          state <= hs_bus;
        end
        else if (cmd == cmd_pace)
        begin
          addr_q <= pace_offset;
          wr_q <= 1'b1;
          req_q <= 1'b1;
          state <= hs_bus;
        end
        else if (cmd == cmd_pulse)
        begin
          hold_q <= 1'b0;
          count <= len_new;
          state <= pwdata[19] ? hs_lag : hs_pulse;
        end
        else
          hold_q <= pwdata[18];
      end
      case (state)
        hs_bus:
          if (link.ack)
          begin
            req_q <= 1'b0;
            state <= hs_idle;
            if (!wr_q)
            begin
              data_q <= link.rdata;
              busy_bit_seen <= link.rdata[busy_bit];
            end
          end
        hs_pulse:
          if (count == 8'h00)
          begin
            hold_q <= 1'b1;
            state <= hs_idle;
          end
          else
            count <= count - 8'h01;
        hs_lag:
          if (count == 8'h00)
          begin
            bypass_q <= 1'b0;
            state <= hs_idle;
          end
          else
            count <= count - 8'h01;
        default: ;
      endcase
    end
  end
endmodule

// ==== hw/aepc_link_if.sv ====
// Interface that joins the register port and pacing lines of the device and its controller.
`timescale 1ns/10ps
interface aepc_link_if;
  logic req;
  logic wr;
  logic [7:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic ack;
  logic pace_bypass_line;
  logic external_hold_line;
  modport device (input req, input wr, input addr, input wdata, output rdata, output ack,
    input pace_bypass_line, input external_hold_line);
  modport host (output req, output wr, output addr, output wdata, input rdata, input ack,
    output pace_bypass_line, output external_hold_line);
endinterface

// ==== hw/aepc_pkg.sv ====
// Package with shared constants and types for the external pacing control block.
package aepc_pkg;
  localparam int unsigned clk_mhz = 125;
  localparam int unsigned free_run_ns = 18000;
  localparam int unsigned free_run_cycles = free_run_ns * clk_mhz / 1000;
  localparam int unsigned start_delay_ns = 3000;
  localparam int unsigned start_delay_cycles = start_delay_ns * clk_mhz / 1000;
  localparam int unsigned pace_step_ns = 600;
  localparam int unsigned pace_step_cycles = pace_step_ns * clk_mhz / 1000;
  localparam int unsigned pulse_min_ns = 1000;
  localparam int unsigned pulse_min_cycles = (pulse_min_ns * clk_mhz + 999) / 1000;
  localparam int unsigned pulse_max_ns = 15000;
  localparam int unsigned pulse_max_cycles = pulse_max_ns * clk_mhz / 1000;
  localparam int unsigned convert_ns = 15000;
  localparam int unsigned convert_cycles = convert_ns * clk_mhz / 1000;
  localparam logic [15:0] pace_base = 16'hfff6;
  localparam logic [15:0] pace_reset = 16'hfff6;
  localparam logic [7:0] pace_offset = 8'h04;
  localparam logic [7:0] data_offset = 8'h40;
  localparam logic [7:0] data_top = 8'h7e;
  localparam int unsigned busy_bit = 15;
  localparam int unsigned pipe_extra = 2;
  localparam logic [11:0] ctl_offset = 12'h000;
  localparam logic [11:0] stat_offset = 12'h004;
  localparam logic [11:0] pace_reg_offset = 12'h008;
  localparam logic [11:0] data_reg_offset = 12'h00c;
  localparam logic [2:0] cmd_read = 3'h1;
  localparam logic [2:0] cmd_pace = 3'h2;
  localparam logic [2:0] cmd_pulse = 3'h4;
  localparam logic [7:0] pulse_len_reset = 8'h40;
  localparam logic [7:0] bypass_lag_reset = 8'h40;
  typedef enum {st_idle, st_wait, st_delay, st_pace, st_convert} aepc_state_t;
  typedef enum {hs_idle, hs_bus, hs_pulse, hs_lag} aepc_host_state_t;
endpackage

// ==== sim/aepc_link_chk.sv ====
// Checker watching the link between the controller end and the device end.
`timescale 1ns/10ps
module aepc_link_chk
  import aepc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req,
  input wire logic wr,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic ack,
  input wire logic pace_bypass_line,
  input wire logic external_hold_line
);
  logic [11:0] lo_cnt;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Counts the cycles the hold line has stayed low, saturating.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lo_cnt <= 12'h000;
    else if (external_hold_line)
      lo_cnt <= 12'h000;
    else if (lo_cnt != 12'hfff)
      lo_cnt <= lo_cnt + 12'h001;
  end
  property p_ack_one;
    ack |=> !ack;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held too long");
  property p_answer;
    $rose(req) |=> ack;
  endproperty
  a_answer: assert property (p_answer) else $error("no ack after request");
  property p_hold_req;
    req && !ack |=> req && $stable(addr) && $stable(wr) && $stable(wdata);
  endproperty
  a_hold_req: assert property (p_hold_req) else $error("request changed before ack");
  property p_wr_addr;
    req && wr |-> addr == pace_offset;
  endproperty
  a_wr_addr: assert property (p_wr_addr) else $error("write outside pace register");
  property p_rd_addr;
    req && !wr |-> addr >= data_offset && addr <= data_top && !addr[0];
  endproperty
  a_rd_addr: assert property (p_rd_addr) else $error("read outside data registers");
  property p_first_byp;
    $fell(external_hold_line) |-> pace_bypass_line;
  endproperty
  a_first_byp: assert property (p_first_byp) else $error("series began with bypass low");
  property p_lag;
    $fell(pace_bypass_line) |-> lo_cnt >= 12'd124 && lo_cnt <= 12'd1875;
  endproperty
  a_lag: assert property (p_lag) else $error("bypass fell outside its window");
  property p_pulse;
    $rose(external_hold_line) && pace_bypass_line |-> lo_cnt >= 12'd125;
  endproperty
  a_pulse: assert property (p_pulse) else $error("hold pulse too short");
  c_read: cover property (ack && !wr && !rdata[15]);
  c_refused: cover property (ack && !wr && rdata[15]);
  c_lag: cover property ($fell(pace_bypass_line));
endmodule

// ==== sim/tb_top.sv ====
// Testbench driving the controller end over APB and timing the conversions.
`timescale 1ns/10ps
module tb_top
  import aepc_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [11:0] sample_in = 12'h000;
  logic hold_d = 1'b1;
  logic pready, pslverr, busy, convert_strobe, last_err;
  logic [31:0] prdata, r;
  logic [3:0] convert_channel;
  logic [15:0] pace = 16'hfff6;
  logic [7:0] idx = 8'h00;
  int seed = 46835;
  int cyc = 0;
  int t_fall = 0;
  int err_total = 0;
  int n_compared = 0;
  int n0, i, m;
  int stq[$];
  aepc_link_if u_aepc_link_if();
  aepc_device u_aepc_device(.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .link(u_aepc_link_if),
    .sample_in(sample_in), .busy(busy), .convert_strobe(convert_strobe), .convert_channel(convert_channel));
  aepc_host u_aepc_host(.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(u_aepc_link_if));
  aepc_link_chk u_aepc_link_chk(.pclk(pclk), .presetn(presetn), .req(u_aepc_link_if.req),
    .wr(u_aepc_link_if.wr), .addr(u_aepc_link_if.addr), .wdata(u_aepc_link_if.wdata),
    .rdata(u_aepc_link_if.rdata), .ack(u_aepc_link_if.ack), .pace_bypass_line(u_aepc_link_if.pace_bypass_line),
    .external_hold_line(u_aepc_link_if.external_hold_line));
  initial
  begin
    forever #4 pclk = ~pclk;
  end
  // Records hold falls and conversion ends in cycle numbers.
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    sample_in <= 12'($random(seed));
    hold_d <= u_aepc_link_if.external_hold_line;
    if (hold_d === 1'b1 && u_aepc_link_if.external_hold_line === 1'b0)
      t_fall <= cyc;
    if (convert_strobe === 1'b1)
      stq.push_back(cyc);
  end
  function automatic logic [31:0] ctl(input logic [2:0] c, input logic lag, input logic h, input logic b,
    input logic [7:0] len);
    return {5'h00, c, 4'h0, lag, h, b, 1'b0, idx, len};
  endfunction
  function automatic int gap(input int mode);
    return mode ? 2250 + 75 * int'(16'hfff6 - pace) : 2250;
  endfunction
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic near(input int got, input int exp);
    chk(32'(got >= exp - 8 && got <= exp + 8), 32'h1);
  endtask
  task automatic hang();
    chk(32'h0, 32'h1);
    finish_test();
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20)
      hang();
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    apb(1'b0, 12'h004, 32'h0);
    while (r[0] !== 1'b0 && n < 400)
    begin
      apb(1'b0, 12'h004, 32'h0);
      n++;
    end
    if (n >= 400)
      hang();
  endtask
  task automatic cmd(input logic [31:0] v);
    apb(1'b1, 12'h000, v);
    wait_idle();
  endtask
  task automatic wait_strobe(input int want);
    int n;
    n = 0;
    while (stq.size() < want && n < 20000)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20000)
      hang();
  endtask
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h008, 32'h0);
    chk(r[15:0], 16'hfff6);
    apb(1'b0, 12'h0f0, 32'h0);
    chk(last_err, 1'b1);
    pace = 16'hfff6 - 16'($random(seed) & 7);
    apb(1'b1, 12'h008, {16'h0000, pace});
    cmd(ctl(cmd_pace, 1'b0, 1'b1, 1'b1, 8'd125));
    apb(1'b0, 12'h008, 32'h0);
    chk(r[15:0], pace);
    $display("test registers done");
    for (i = 0; i < 3; i++)
    begin
      idx = 8'($random(seed) & 31);
      cmd(ctl(cmd_read, 1'b0, 1'b1, 1'b1, 8'd125));
      n0 = stq.size();
      repeat (3000) @(posedge pclk);
      chk(stq.size(), n0);
      chk(busy, 1'b1);
      cmd(ctl(cmd_pulse, 1'b0, 1'b1, 1'b1, 8'd200));
      wait_strobe(n0 + 1);
      repeat (2500) @(posedge pclk);
      chk(stq.size(), n0 + 1);
      near(stq[n0] - t_fall, 2252);
    end
    apb(1'b0, 12'h00c, 32'h0);
    chk(r[15], 1'b0);
    $display("test single readings done");
    for (m = 0; m < 2; m++)
    begin
      n0 = stq.size();
      for (i = 0; i < 3; i++)
        cmd(ctl(cmd_read, 1'b0, 1'b1, 1'b1, 8'd125));
      apb(1'b0, 12'h00c, 32'h0);
      chk(r[15], 1'b1);
      cmd(m ? ctl(cmd_pulse, 1'b1, 1'b1, 1'b1, 8'd125) : ctl(3'h0, 1'b0, 1'b0, 1'b1, 8'd125));
      for (i = 1; i <= 3; i++)
      begin
        wait_strobe(n0 + i);
        if (i == 1)
          near(stq[n0] - t_fall, 2252);
        if (i > 1)
          near(stq[n0 + i - 1] - stq[n0 + i - 2], gap(m));
      end
      repeat (3000) @(posedge pclk);
      chk(stq.size(), n0 + 3);
      cmd(ctl(3'h0, 1'b0, 1'b1, 1'b1, 8'd125));
      $display("test burst mode %0d done", m);
    end
    finish_test();
  end
endmodule
